// >>> include/epp_pkg.sv
/*
 * Shared constants and types for the enhanced parallel port cycle
 * sequencer: watchdog timing, reset values and sequencer states.
 * Assumes a single 125 MHz core clock.
 */
`default_nettype none

package epp_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;     // Core clock period
	localparam int unsigned WD_TIME_NS    = 10000; // Watchdog limit, 10 us
	// Longest time: rounded down to whole cycles
	localparam int unsigned WD_CYCLES     = WD_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned WD_WIDTH      = 11;    // Holds WD_CYCLES

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] DATA_RST = 8'h00;       // Address/data latches
	localparam logic [3:0] NIB_RST  = 4'h0;        // Host nibble output

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,    // No port cycle
		ST_ARM,     // Waiting for the peripheral to signal ready
		ST_SETUP,   // Data, direction and write select settle
		ST_STROBE,  // Strobe active, waiting for wait line high
		ST_SYNC,    // Ready sync to host
		ST_NIB_LO,  // Read data, low nibble
		ST_NIB_HI,  // Read data, high nibble
		ST_TAR      // Turnaround, host cycle ends
	} cyc_state_e;

endpackage

`default_nettype wire

// >>> logic/epp_cycle_sequencer.sv
/*
 * Enhanced parallel port cycle sequencer: turns host port cycles into
 * strobe and wait handshakes, holds the host with wait syncs, and
 * aborts on a 10 us watchdog. Supports the 1.9 and 1.7 variants.
 * Assumes a host front end that presents one cycle request and takes
 * sync, nibble and turnaround indications back; pins are synchronous.
 */
`default_nettype none

module epp_cycle_sequencer (
	// Clock, reset, enable
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Mode
	input  wire logic       variant_17,
	input  wire logic       timeout_select,
	// Standard control bits and data
	input  wire logic       ctl_strobe,
	input  wire logic       ctl_autofd,
	input  wire logic       ctl_init,
	input  wire logic       ctl_slctin,
	input  wire logic       control_direction_bit,
	input  wire logic [7:0] spp_data,
	// Host cycle request
	input  wire logic       host_start,
	input  wire logic       host_write,
	input  wire logic       host_addr,
	input  wire logic [7:0] host_wdata,
	// Host cycle answer
	output logic            lad_sync_wait,
	output logic            lad_sync_ready,
	output logic            lad_nib_valid,
	output logic [3:0]      lad_nib,
	output logic            lad_tar,
	output logic [7:0]      host_rdata,
	// Status access
	input  wire logic       stat_wr,
	input  wire logic       stat_wdata0,
	input  wire logic       stat_rd_end,
	output logic            cycle_timeout_flag,
	// Port pins
	output logic [7:0]      port_data_bus_o,
	output logic            port_data_bus_oe,
	input  wire logic [7:0] port_data_bus_i,
	output logic            port_direction_bit,
	output logic            write_select_n,
	output logic            data_strobe_n,
	output logic            addr_strobe_out_n,
	output logic            peripheral_reset_n,
	input  wire logic       peripheral_wait_n,
	input  wire logic       peripheral_interrupt,
	output logic            irq_out
);

	// ------------------------------------------------------------------
	// Cycle state
	// ------------------------------------------------------------------
	epp_pkg::cyc_state_e state_q, state_d; // Sequencer state
	logic       write_q, write_d;          // Cycle is a host write
	logic       addr_q, addr_d;            // Cycle uses address strobe
	logic [7:0] wdata_q, wdata_d;          // Byte latched for the port
	logic [7:0] rdata_q, rdata_d;          // Byte captured from port
	logic       hold_q, hold_d;            // Pins held until wait low
	logic       flag_q, flag_d;            // Timeout flag
	logic       abort;                     // Watchdog abort this cycle
	logic       wd_run;                    // Watchdog counting
	logic       wd_expired;                // Watchdog limit passed

	// Watchdog runs from cycle start to wait release
	assign wd_run = (state_q == epp_pkg::ST_ARM) ||
		(state_q == epp_pkg::ST_SETUP) || (state_q == epp_pkg::ST_STROBE);

	epp_watchdog u_watchdog (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.run     (wd_run),
		.expired (wd_expired)
	);

	// Next state of the sequencer and its latches
	always_comb begin
		state_d = state_q;
		write_d = write_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		hold_d  = hold_q;
		abort   = 1'b0;
		// Peripheral back at ready: cycle pins may change again
		if (!peripheral_wait_n && state_q != epp_pkg::ST_STROBE) begin
			hold_d = 1'b0;
		end
		case (state_q)
			epp_pkg::ST_IDLE: begin
				if (host_start) begin
					write_d = host_write;
					addr_d  = host_addr;
					wdata_d = host_write ? host_wdata : wdata_q;
					// 1.7 relies on software having set direction
					state_d = variant_17 ? epp_pkg::ST_SETUP
						: epp_pkg::ST_ARM;
				end
			end
			epp_pkg::ST_ARM: begin
				if (!peripheral_wait_n) begin
					state_d = epp_pkg::ST_SETUP;
				end else if (wd_expired) begin
					abort   = 1'b1;
					state_d = epp_pkg::ST_SYNC;
				end
			end
			epp_pkg::ST_SETUP: begin
				state_d = epp_pkg::ST_STROBE;
			end
			epp_pkg::ST_STROBE: begin
				if (peripheral_wait_n) begin
					// Peripheral done with setup or data valid
					if (!write_q) begin
						rdata_d = port_data_bus_i;
					end
					hold_d  = 1'b1;
					state_d = epp_pkg::ST_SYNC;
				end else if (wd_expired) begin
					abort   = 1'b1;
					state_d = epp_pkg::ST_SYNC;
				end
			end
			epp_pkg::ST_SYNC: begin
				state_d = write_q ? epp_pkg::ST_TAR
					: epp_pkg::ST_NIB_LO;
			end
			epp_pkg::ST_NIB_LO: begin
				state_d = epp_pkg::ST_NIB_HI;
			end
			epp_pkg::ST_NIB_HI: begin
				state_d = epp_pkg::ST_TAR;
			end
			epp_pkg::ST_TAR: begin
				state_d = epp_pkg::ST_IDLE;
			end
			default: begin
				state_d = epp_pkg::ST_IDLE;
			end
		endcase
		// Flag set wins over any clear in the same cycle
		if (abort) begin
			flag_d = 1'b1;
		end else if (!timeout_select && stat_wr && stat_wdata0) begin
			flag_d = 1'b0;
		end else if (timeout_select && stat_rd_end) begin
			flag_d = 1'b0;
		end else begin
			flag_d = flag_q;
		end
	end

	// Register the sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= epp_pkg::ST_IDLE;
			write_q <= 1'b0;
			addr_q  <= 1'b0;
			wdata_q <= epp_pkg::DATA_RST;
			rdata_q <= epp_pkg::DATA_RST;
			hold_q  <= 1'b0;
			flag_q  <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			write_q <= write_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			hold_q  <= hold_d;
			flag_q  <= flag_d;
		end
	end

	// ------------------------------------------------------------------
	// Pin and host outputs
	// ------------------------------------------------------------------
	logic       in_cyc;   // Cycle owns the port pins
	logic       wr_eff;   // Effective write direction
	logic       strobe_on;
	logic [7:0] pd_d;
	logic       oe_d, wsel_n_d, dstb_n_d, astb_n_d;
	logic       sw_d, sr_d, nv_d, tar_d;
	logic [3:0] nib_d;

	assign in_cyc = hold_q || (state_q inside {epp_pkg::ST_SETUP,
		epp_pkg::ST_STROBE, epp_pkg::ST_SYNC, epp_pkg::ST_NIB_LO,
		epp_pkg::ST_NIB_HI, epp_pkg::ST_TAR});
	assign strobe_on = (state_q == epp_pkg::ST_STROBE);

	// Next pin levels and host indications
	always_comb begin
		// 1.7 direction comes from the control bit, 1.9 from the cycle
		wr_eff = variant_17 ? !control_direction_bit : write_q;
		if (in_cyc) begin
			// Strobe bit forces write direction and write select
			oe_d     = wr_eff || ctl_strobe;
			wsel_n_d = !(wr_eff || ctl_strobe);
			dstb_n_d = !(strobe_on && !addr_q);
			astb_n_d = !(strobe_on && addr_q);
			pd_d     = wdata_q;
		end else begin
			// Standard port behaviour between cycles
			oe_d     = !control_direction_bit;
			wsel_n_d = !ctl_strobe;
			dstb_n_d = !ctl_autofd;
			astb_n_d = !ctl_slctin;
			pd_d     = spp_data;
		end
		// Host answer follows the next state
		sw_d  = state_d inside {epp_pkg::ST_ARM, epp_pkg::ST_SETUP,
			epp_pkg::ST_STROBE};
		sr_d  = (state_d == epp_pkg::ST_SYNC);
		nv_d  = (state_d == epp_pkg::ST_NIB_LO) ||
			(state_d == epp_pkg::ST_NIB_HI);
		nib_d = (state_d == epp_pkg::ST_NIB_HI) ? rdata_d[7:4]
			: (nv_d ? rdata_d[3:0] : epp_pkg::NIB_RST);
		tar_d = (state_d == epp_pkg::ST_TAR);
	end

	// Register the port pins, irq_out and the host sync, nibble and turnaround outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			port_data_bus_o    <= epp_pkg::DATA_RST;
			port_data_bus_oe   <= 1'b1;
			write_select_n     <= 1'b1;
			data_strobe_n      <= 1'b1;
			addr_strobe_out_n  <= 1'b1;
			peripheral_reset_n <= 1'b0;
			irq_out            <= 1'b0;
			lad_sync_wait      <= 1'b0;
			lad_sync_ready     <= 1'b0;
			lad_nib_valid      <= 1'b0;
			lad_nib            <= epp_pkg::NIB_RST;
			lad_tar            <= 1'b0;
		end else if (ce) begin
			port_data_bus_o    <= pd_d;
			port_data_bus_oe   <= oe_d;
			write_select_n     <= wsel_n_d;
			data_strobe_n      <= dstb_n_d;
			addr_strobe_out_n  <= astb_n_d;
			peripheral_reset_n <= ctl_init;
			irq_out            <= peripheral_interrupt;
			lad_sync_wait      <= sw_d;
			lad_sync_ready     <= sr_d;
			lad_nib_valid      <= nv_d;
			lad_nib            <= nib_d;
			lad_tar            <= tar_d;
		end
	end

	assign port_direction_bit = !port_data_bus_oe;
	assign cycle_timeout_flag = flag_q;
	assign host_rdata         = rdata_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !ce);

	sequence s_read_tail;
		lad_sync_ready ##1 lad_nib_valid && lad_nib == rdata_q[3:0]
		##1 lad_nib_valid && lad_nib == rdata_q[7:4] ##1 lad_tar;
	endsequence

	a_ready_before_strobe: assert property (
		(state_q == epp_pkg::ST_SETUP && !variant_17)
		|-> $past(!peripheral_wait_n))
		else $error("strobe phase began without wait low");

	a_write_setup: assert property (
		(state_q == epp_pkg::ST_STROBE && $past(state_q) ==
		epp_pkg::ST_SETUP && write_q && !variant_17)
		|-> !write_select_n && port_data_bus_oe && port_data_bus_o == wdata_q)
		else $error("write pins not set before strobe");

	a_read_setup: assert property (
		(state_q == epp_pkg::ST_STROBE && !write_q && !variant_17
		&& !ctl_strobe && !$past(ctl_strobe))
		|=> write_select_n && !port_data_bus_oe && port_direction_bit)
		else $error("read pins not set during strobe");

	a_strobe_release: assert property (
		(strobe_on && peripheral_wait_n)
		|=> lad_sync_ready ##1 data_strobe_n && addr_strobe_out_n)
		else $error("strobe not released after wait high");

	a_read_capture: assert property (
		(strobe_on && peripheral_wait_n && !write_q)
		|=> rdata_q == $past(port_data_bus_i))
		else $error("read byte not captured");

	a_read_answer: assert property (
		(state_q == epp_pkg::ST_SYNC && !write_q) |-> s_read_tail)
		else $error("read answer out of order");

	a_wait_stretch: assert property (
		(strobe_on && !peripheral_wait_n && !wd_expired)
		|=> lad_sync_wait && !lad_sync_ready)
		else $error("host not held while wait low");

	a_abort_path: assert property (
		(wd_run && wd_expired && !peripheral_wait_n && strobe_on)
		|=> cycle_timeout_flag && lad_sync_ready
		##1 data_strobe_n && addr_strobe_out_n)
		else $error("abort did not flag and complete");

	a_flag_read_clear: assert property (
		(timeout_select && stat_rd_end && !abort) |=> !cycle_timeout_flag)
		else $error("timeout flag not cleared by read");

	a_idle_follow: assert property (
		(state_q == epp_pkg::ST_IDLE && !hold_q)
		|=> write_select_n == !$past(ctl_strobe)
		&& port_data_bus_oe == !$past(control_direction_bit))
		else $error("idle pins do not follow control");

	a_force_write: assert property (
		(in_cyc && ctl_strobe) |=> port_data_bus_oe && !write_select_n)
		else $error("strobe bit did not force write");

endmodule

`default_nettype wire

// >>> logic/epp_watchdog.sv
/*
 * Cycle watchdog: counts core cycles while a port cycle runs and
 * raises expiry once the limit has passed and holds it while run stays high.
 * Assumes run drops between cycles so that the count restarts.
 */
`default_nettype none

module epp_watchdog #(
	parameter int unsigned LIMIT = epp_pkg::WD_CYCLES,
	parameter int unsigned WIDTH = epp_pkg::WD_WIDTH
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Control and result
	input  wire logic run,
	output logic      expired
);

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);

	logic [WIDTH-1:0] cnt_q; // Cycles spent in the current cycle
	logic [WIDTH-1:0] cnt_d;

	// Next count: clear when idle, saturate at the limit
	always_comb begin
		if (!run) begin
			cnt_d = '0;
		end else if (cnt_q == LIM) begin
			cnt_d = cnt_q;
		end else begin
			cnt_d = cnt_q + WIDTH'(1);
		end
	end

	// Register the count
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	// Expiry while the limit is reached and the cycle still runs
	assign expired = run && (cnt_q == LIM);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_wd_no_early: assert property (@(posedge ref_clk)
		disable iff (!rst_n || !ce)
		(run && !expired) |-> (cnt_q < LIM))
		else $error("watchdog count passed the limit");

endmodule

`default_nettype wire

// >>> tb/epp_peripheral.sv
/*
 * Peripheral model for the enhanced parallel port: answers each strobe
 * with the wait line handshake and drives read bytes.
 * Assumes the bench resolves the shared data bus from the device output enable alone.
 */
`default_nettype none

module epp_peripheral (
	// Clock
	input  wire logic       ref_clk,
	// Port strobes
	input  wire logic       data_strobe_n,
	input  wire logic       addr_strobe_out_n,
	input  wire logic       write_select_n,
	// Bench controls
	input  wire logic       busy,
	input  wire logic       hang,
	input  wire logic [7:0] rd_byte,
	// Wait line and bus
	output logic            wait_n,
	output logic            drive,
	output logic [7:0]      data
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] cnt_q; // Cycles since strobe fell

	initial begin
		wait_n = 1'b0;
		drive  = 1'b0;
		data   = 8'h5A;
		cnt_q  = 2'h0;
	end

	// Handshake: setup delay, then data, then wait high
	always @(posedge ref_clk) begin
		if (data_strobe_n && addr_strobe_out_n) begin
			drive  <= 1'b0;            // Float bus first
			wait_n <= busy | drive;    // Then ready again
			cnt_q  <= 2'h0;
		end else if (cnt_q != 2'h3) begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == 2'h1 && write_select_n)
				drive <= 1'b1;         // Read data valid
			if (cnt_q == 2'h2 && !hang)
				wait_n <= 1'b1;        // Setup met or data valid
		end
		// Released bus inverts every bit each cycle, showing the last byte every other cycle
		if (drive)
			data <= rd_byte;
		else
			data <= ~data;
	end
endmodule

`default_nettype wire

// >>> tb/tb_epp_cycle_sequencer.sv
/*
 * Bench for the port cycle sequencer: idle mapping, 1.9 and 1.7
 * cycles, wait-line stalls and watchdog aborts.
 * Assumes the peripheral model and a 125 MHz clock.
 */
`default_nettype none

module tb_epp_cycle_sequencer;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic       ref_clk, rst_n, ce, variant_17, timeout_select;
	logic       ctl_strobe, ctl_autofd, ctl_init, ctl_slctin;
	logic       control_direction_bit, host_start, host_write, host_addr;
	logic       stat_wr, stat_wdata0, stat_rd_end, cycle_timeout_flag;
	logic       lad_sync_wait, lad_sync_ready, lad_nib_valid, lad_tar;
	logic       port_data_bus_oe, port_direction_bit, write_select_n;
	logic       data_strobe_n, addr_strobe_out_n, peripheral_reset_n;
	logic       wait_n, peripheral_interrupt, irq_out, busy, hang, drive;
	logic [3:0] lad_nib;
	logic [7:0] spp_data, host_wdata, host_rdata, rd_byte, data;
	logic [7:0] port_data_bus_o, port_data_bus_i;
	int         miscompares, checks, s_len, s_nnib;
	// Pins seen at the first strobe-low sample, and host answers
	logic [7:0] s_bus, s_rbus, s_nibs;
	logic       s_oe, s_ws, s_ds, s_as, s_dir, s_wt, s_ready;

	// Shared bus: device output when enabled, else the peripheral
	assign port_data_bus_i = port_data_bus_oe ? port_data_bus_o : data;

	epp_cycle_sequencer DUT (.ref_clk, .rst_n, .ce, .variant_17,
		.timeout_select, .ctl_strobe, .ctl_autofd, .ctl_init, .ctl_slctin,
		.control_direction_bit, .spp_data, .host_start, .host_write,
		.host_addr, .host_wdata, .lad_sync_wait, .lad_sync_ready,
		.lad_nib_valid, .lad_nib, .lad_tar, .host_rdata, .stat_wr,
		.stat_wdata0, .stat_rd_end, .cycle_timeout_flag, .port_data_bus_o,
		.port_data_bus_oe, .port_data_bus_i, .port_direction_bit,
		.write_select_n, .data_strobe_n, .addr_strobe_out_n,
		.peripheral_reset_n, .peripheral_wait_n(wait_n),
		.peripheral_interrupt, .irq_out);

	epp_peripheral periph (.ref_clk, .data_strobe_n, .addr_strobe_out_n,
		.write_select_n, .busy, .hang, .rd_byte, .wait_n, .drive, .data);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One host cycle, recording pins and answers until turnaround
	task automatic run_cycle(input logic wr, ad, input logic [7:0] wd);
		@(negedge ref_clk);
		host_write = wr;
		host_addr  = ad;
		host_wdata = wd;
		host_start = 1'b1;
		@(negedge ref_clk);
		host_start = 1'b0;
		{s_ds, s_as, s_ready, s_nibs} = {3'b110, 8'h00};
		s_nnib = 0;
		for (s_len = 1; s_len < 2000 && lad_tar !== 1'b1; s_len++) begin
			if ((!data_strobe_n || !addr_strobe_out_n) && s_ds && s_as) begin
				{s_ds, s_as, s_ws} = {data_strobe_n, addr_strobe_out_n,
					write_select_n};
				{s_bus, s_oe, s_dir} = {port_data_bus_o, port_data_bus_oe,
					port_direction_bit};
				s_wt = lad_sync_wait;
			end
			if (lad_sync_ready === 1'b1) begin
				s_ready = 1'b1;
				s_rbus  = port_data_bus_o;
			end
			if (lad_nib_valid === 1'b1 && s_ready) begin
				s_nibs = {lad_nib, s_nibs[7:4]};
				s_nnib++;
			end
			@(negedge ref_clk);
		end
		check("turnaround", lad_tar, 8'h01);
		@(negedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Idle pins follow control bits, reset and interrupt pass through
	task automatic t_idle();
		{ctl_strobe, ctl_autofd, ctl_slctin, control_direction_bit} = 4'hF;
		peripheral_interrupt = 1'b1;
		repeat (2) @(negedge ref_clk);
		check("idle select", write_select_n, 8'h00);
		check("idle addr strobe", addr_strobe_out_n, 8'h00);
		check("idle data strobe", data_strobe_n, 8'h00);
		check("idle direction", port_direction_bit, 8'h01);
		check("irq high", irq_out, 8'h01);
		check("reset off", peripheral_reset_n, 8'h01);
		{ctl_strobe, ctl_autofd, ctl_slctin, control_direction_bit} = 4'h0;
		{ctl_init, peripheral_interrupt} = 2'b00;
		repeat (4) @(negedge ref_clk);
		check("idle bus", port_data_bus_o, 8'hC3);
		check("idle oe", port_data_bus_oe, 8'h01);
		check("irq low", irq_out, 8'h00);
		check("reset on", peripheral_reset_n, 8'h00);
		// Clock enable low: pins hold although the controls move
		{ce, ctl_init, ctl_strobe} = 3'b011;
		repeat (2) @(negedge ref_clk);
		check("frozen select", write_select_n, 8'h01);
		check("frozen reset", peripheral_reset_n, 8'h00);
		{ce, ctl_strobe} = 2'b10;
	endtask

	// 1.9 write held back while the peripheral is not ready
	task automatic t_write19();
		busy = 1'b1;
		repeat (3) @(negedge ref_clk);
		fork
			run_cycle(1'b1, 1'b0, 8'hA5);
			begin
				repeat (12) @(negedge ref_clk);
				check("no strobe", data_strobe_n, 8'h01);
				busy = 1'b0;
			end
		join
		check("write byte", s_bus, 8'hA5);
		check("write oe", s_oe, 8'h01);
		check("write sel", s_ws, 8'h00);
		check("write strobes", {s_ds, s_as}, 8'h01);
		check("write wait", s_wt, 8'h01);
		check("write ready", s_ready, 8'h01);
		check("byte kept", s_rbus, 8'hA5);
		check("no nibbles", s_nnib[7:0], 8'h00);
	endtask

	// Read with the peripheral's byte returned low nibble first
	task automatic t_read(input logic v17, ad, input logic [7:0] b);
		{variant_17, control_direction_bit, rd_byte} = {v17, v17, b};
		run_cycle(1'b0, ad, 8'h00);
		check("read oe", s_oe, 8'h00);
		check("read sel", s_ws, 8'h01);
		check("read dir", s_dir, 8'h01);
		check("read strobes", {s_ds, s_as}, {6'h00, ad, !ad});
		check("read ready", s_ready, 8'h01);
		check("nibbles", s_nibs, b);
		check("nibble count", s_nnib[7:0], 8'h02);
		check("captured", host_rdata, b);
	endtask

	// Strobe bit held during a 1.9 read forces write direction
	task automatic t_forced();
		{variant_17, control_direction_bit, ctl_strobe} = 3'b001;
		run_cycle(1'b0, 1'b0, 8'h00);
		ctl_strobe = 1'b0;
		check("forced oe", s_oe, 8'h01);
		check("forced sel", s_ws, 8'h00);
	endtask

	// Peripheral never answers: abort, flag, then clear the flag
	task automatic t_abort(input logic v17, sel, input logic [7:0] b);
		{variant_17, control_direction_bit, hang} = {v17, 2'b01};
		timeout_select = sel;
		run_cycle(1'b1, 1'b1, b);
		hang = 1'b0;
		check("aborted byte", s_bus, b);
		check("abort length", {7'h00, s_len > 1250}, 8'h01);
		check("flag set", cycle_timeout_flag, 8'h01);
		check("strobe off", addr_strobe_out_n, 8'h01);
		stat_wdata0 = 1'b0;
		stat_wr     = 1'b1;
		@(negedge ref_clk);
		stat_wr = 1'b0;
		@(negedge ref_clk);
		check("write zero", cycle_timeout_flag, 8'h01);
		{stat_wr, stat_wdata0, stat_rd_end} = {!sel, !sel, sel};
		@(negedge ref_clk);
		{stat_wr, stat_wdata0, stat_rd_end} = 3'b000;
		@(negedge ref_clk);
		check("flag cleared", cycle_timeout_flag, 8'h00);
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end

	initial begin
		{miscompares, checks, rst_n, variant_17, timeout_select} = 0;
		ce = 1'b1;
		{ctl_strobe, ctl_autofd, ctl_slctin, control_direction_bit} = 4'h0;
		{ctl_init, host_start, host_write, host_addr} = 4'h8;
		{stat_wr, stat_wdata0, stat_rd_end, peripheral_interrupt} = 4'h0;
		{busy, hang, spp_data, host_wdata, rd_byte} = {2'b00, 24'hC30000};
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		t_idle();
		t_write19();
		t_read(1'b0, 1'b1, 8'h3C);
		t_read(1'b1, 1'b0, 8'h96);
		t_forced();
		t_abort(1'b0, 1'b0, 8'h11);
		t_abort(1'b1, 1'b1, 8'h22);
		conclude();
	end
endmodule

`default_nettype wire
